// >>> design/emtn_pkg.sv
package emtn_pkg;
  // register byte offsets on the slave port
  localparam logic [3:0] EXT_TIMING_ADDR = 4'h0;
  localparam logic [3:0] NAND_CTRL_ADDR = 4'h4;
  localparam int ADDR_W = 4;

  // static bank extra timing fields
  localparam int R2R_LSB = 8;
  localparam int W2W_LSB = 0;
  localparam int TURN_W = 8;
  localparam logic [31:0] EXT_RW_MASK = 32'h0000ffff;
  localparam logic [31:0] EXT_RESET = 32'h00000808;

  // nand bank control fields
  localparam int ECC_PGS_LSB = 17;
  localparam int ECC_PGS_W = 3;
  localparam int TAR_LSB = 13;
  localparam int TCR_LSB = 9;
  localparam int LAT_W = 4;
  localparam int ECC_EN_BIT = 6;
  localparam int WIDTH_LSB = 4;
  localparam int WIDTH_W = 2;
  localparam int DEV_BIT = 3;
  localparam int EN_BIT = 2;
  localparam int WAIT_BIT = 1;
  localparam logic [31:0] NAND_RW_MASK = 32'h000ffe7e;
  localparam logic [31:0] NAND_RESET = 32'h00000018;

  // bus width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;

  typedef enum logic [1:0] {
    NAND_IDLE,
    NAND_LATCH,
    NAND_DELAY,
    NAND_STROBE
  } emtn_nand_state_t;
endpackage : emtn_pkg

// >>> design/emtn_delay_cnt.sv
`timescale 1ns/10ps
module emtn_delay_cnt #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // load and status
  input wire logic load_in,
  input wire logic [WIDTH-1:0] value_in,
  output logic busy_out,
  output logic last_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = value_in;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_out = (cnt_q != '0);
  assign last_out = (cnt_q == '0);
endmodule : emtn_delay_cnt

// >>> design/emtn_ctrl.sv
// Overview of operation
// RULE_01: back-to-back reads on the static bank are spaced by read field plus one cycles
// RULE_02: back-to-back writes on the static bank are spaced by write field plus one cycles
// RULE_03: read strobe falls address-latch field plus one cycles after address latch falls
// RULE_04: read strobe falls command-latch field plus one cycles after command latch falls
// RULE_05: width code 00 drives eight data bits, 01 sixteen; others reserved
// RULE_06: no nand bank access while the bank enable bit is clear
// RULE_07: with wait enabled, busy stretches the strobe; otherwise busy is ignored
// RULE_08: reserved bits read reset value; turnaround only for same-direction neighbours
`timescale 1ns/10ps
module emtn_ctrl #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // avalon-mm register slave
  input wire logic [emtn_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // static bank access requests
  input wire logic sram_req_in,
  input wire logic sram_we_in,
  output logic sram_grant_out,
  // nand operation requests
  input wire logic nand_req_in,
  input wire logic nand_addr_phase_in,
  input wire logic [DATA_W-1:0] nand_byte_in,
  output logic nand_ready_out,
  output logic nand_done_out,
  output logic [DATA_W-1:0] nand_rdata_out,
  // nand pins
  output logic nand_ce_n_out,
  output logic nand_cle_out,
  output logic nand_ale_out,
  output logic nand_we_n_out,
  output logic nand_re_n_out,
  output logic [DATA_W-1:0] nand_d_out,
  output logic [1:0] nand_d_oe_out,
  input wire logic [DATA_W-1:0] nand_d_in,
  input wire logic nand_rb_n_in
);
  localparam int HALF = DATA_W / 2;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] be, input logic [31:0] rwm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rwm;
    merge = (old & ~m) | (wdat & m);
  endfunction : merge

  // ---------------- register slave ----------------
  logic [31:0] ext_q, ext_d, nand_q, nand_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_take;

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign wr_take = avs_write_in & ack_q;

  always_comb begin
    ack_d = (avs_read_in | avs_write_in) & ~ack_q;
    rdata_d = rdata_q;
    ext_d = ext_q;
    nand_d = nand_q;
    if (avs_read_in && !ack_q) begin
      case (avs_address_in)
        emtn_pkg::EXT_TIMING_ADDR: rdata_d = ext_q;
        emtn_pkg::NAND_CTRL_ADDR: rdata_d = nand_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr_take && avs_address_in == emtn_pkg::EXT_TIMING_ADDR) begin
      ext_d = merge(ext_q, avs_writedata_in, avs_byteenable_in, emtn_pkg::EXT_RW_MASK); // see RULE_08
    end
    if (wr_take && avs_address_in == emtn_pkg::NAND_CTRL_ADDR) begin
      nand_d = merge(nand_q, avs_writedata_in, avs_byteenable_in, emtn_pkg::NAND_RW_MASK); // see RULE_08
      // a reserved width code would leave the pins undefined, so keep the old width
      if (nand_d[emtn_pkg::WIDTH_LSB +: emtn_pkg::WIDTH_W] != emtn_pkg::WIDTH_8 &&
          nand_d[emtn_pkg::WIDTH_LSB +: emtn_pkg::WIDTH_W] != emtn_pkg::WIDTH_16) begin
        nand_d[emtn_pkg::WIDTH_LSB +: emtn_pkg::WIDTH_W] =
          nand_q[emtn_pkg::WIDTH_LSB +: emtn_pkg::WIDTH_W]; // see RULE_05
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ext_q <= emtn_pkg::EXT_RESET;
      nand_q <= emtn_pkg::NAND_RESET;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ext_q <= ext_d;
      nand_q <= nand_d;
    end
  end

  assign avs_readdata_out = rdata_q;

  logic [emtn_pkg::TURN_W-1:0] r2r_f, w2w_f;
  logic [emtn_pkg::LAT_W-1:0] tar_f, tcr_f;
  logic bank_en, wait_en, wide;
  assign r2r_f = ext_q[emtn_pkg::R2R_LSB +: emtn_pkg::TURN_W];
  assign w2w_f = ext_q[emtn_pkg::W2W_LSB +: emtn_pkg::TURN_W];
  assign tar_f = nand_q[emtn_pkg::TAR_LSB +: emtn_pkg::LAT_W];
  assign tcr_f = nand_q[emtn_pkg::TCR_LSB +: emtn_pkg::LAT_W];
  assign bank_en = nand_q[emtn_pkg::EN_BIT];
  assign wait_en = nand_q[emtn_pkg::WAIT_BIT];
  assign wide = (nand_q[emtn_pkg::WIDTH_LSB +: emtn_pkg::WIDTH_W] == emtn_pkg::WIDTH_16);

  // ---------------- static bank turnaround ----------------
  logic rd_busy, wr_busy, rd_grant, wr_grant;
  assign sram_grant_out = sram_req_in & (sram_we_in ? ~wr_busy : ~rd_busy); // see RULE_01
  assign rd_grant = sram_grant_out & ~sram_we_in;
  assign wr_grant = sram_grant_out & sram_we_in;

  // an opposite-direction grant reloads zero: the gap only guards same-direction pairs
  emtn_delay_cnt #(.WIDTH(emtn_pkg::TURN_W + 1)) u_rd_turn (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .load_in(sram_grant_out),
    .value_in(rd_grant ? {1'b0, r2r_f} + 9'h001 : 9'h000), // see RULE_01 RULE_08
    .busy_out(rd_busy),
    .last_out()
  );

  emtn_delay_cnt #(.WIDTH(emtn_pkg::TURN_W + 1)) u_wr_turn (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .load_in(sram_grant_out),
    .value_in(wr_grant ? {1'b0, w2w_f} + 9'h001 : 9'h000), // see RULE_02 RULE_08
    .busy_out(wr_busy),
    .last_out()
  );

  // ---------------- nand sequencer ----------------
  logic [1:0] rb_sync_q;
  logic [DATA_W-1:0] d_s1_q, d_s2_q;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rb_sync_q <= 2'h3;
      d_s1_q <= '0;
      d_s2_q <= '0;
    end else begin
      rb_sync_q <= {rb_sync_q[0], nand_rb_n_in};
      d_s1_q <= nand_d_in;
      d_s2_q <= d_s1_q;
    end
  end

  emtn_pkg::emtn_nand_state_t st_q, st_d;
  logic kind_q, kind_d;
  logic wide_q, wide_d;
  logic [emtn_pkg::LAT_W-1:0] dly_q, dly_d;
  logic [DATA_W-1:0] wbyte_q, wbyte_d, rdata_nq, rdata_nd;
  logic done_q, done_d;
  logic cle_q, ale_q, we_n_q, re_n_q, ce_n_q;
  logic cle_d, ale_d, we_n_d, re_n_d, ce_n_d;
  logic [1:0] oe_q, oe_d;
  logic lat_last, mem_busy;

  assign mem_busy = ~rb_sync_q[1];
  assign nand_ready_out = bank_en & (st_q == emtn_pkg::NAND_IDLE); // see RULE_06

  emtn_delay_cnt #(.WIDTH(emtn_pkg::LAT_W)) u_lat_dly (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .load_in(st_q == emtn_pkg::NAND_LATCH),
    .value_in(dly_q),
    .busy_out(),
    .last_out(lat_last)
  );

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    wide_d = wide_q;
    dly_d = dly_q;
    wbyte_d = wbyte_q;
    rdata_nd = rdata_nq;
    done_d = 1'b0;
    case (st_q)
      emtn_pkg::NAND_IDLE: begin
        if (nand_req_in && bank_en) begin // see RULE_06
          st_d = emtn_pkg::NAND_LATCH;
          kind_d = nand_addr_phase_in;
          wide_d = wide;
          dly_d = nand_addr_phase_in ? tar_f : tcr_f; // see RULE_03 RULE_04
          wbyte_d = nand_byte_in;
        end
      end
      emtn_pkg::NAND_LATCH: st_d = emtn_pkg::NAND_DELAY;
      emtn_pkg::NAND_DELAY: begin
        if (lat_last) begin
          st_d = emtn_pkg::NAND_STROBE;
        end
      end
      emtn_pkg::NAND_STROBE: begin
        if (!(wait_en && mem_busy)) begin // see RULE_07
          st_d = emtn_pkg::NAND_IDLE;
          done_d = 1'b1;
          rdata_nd = wide_q ? d_s2_q : {{HALF{1'b0}}, d_s2_q[HALF-1:0]}; // see RULE_05
        end
      end
      default: st_d = emtn_pkg::NAND_IDLE;
    endcase
    // pins follow the next state so that they leave flip-flops in step with it
    cle_d = (st_d == emtn_pkg::NAND_LATCH) & ~kind_d;
    ale_d = (st_d == emtn_pkg::NAND_LATCH) & kind_d;
    we_n_d = (st_d != emtn_pkg::NAND_LATCH);
    re_n_d = (st_d != emtn_pkg::NAND_STROBE);
    ce_n_d = (st_d == emtn_pkg::NAND_IDLE);
    oe_d = (st_d == emtn_pkg::NAND_LATCH) ? {wide_d, 1'b1} : 2'h0; // see RULE_05
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= emtn_pkg::NAND_IDLE;
      kind_q <= 1'b0;
      wide_q <= 1'b1;
      dly_q <= '0;
      wbyte_q <= '0;
      rdata_nq <= '0;
      done_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      oe_q <= 2'h0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      wide_q <= wide_d;
      dly_q <= dly_d;
      wbyte_q <= wbyte_d;
      rdata_nq <= rdata_nd;
      done_q <= done_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      ce_n_q <= ce_n_d;
      oe_q <= oe_d;
    end
  end

  assign nand_cle_out = cle_q;
  assign nand_ale_out = ale_q;
  assign nand_we_n_out = we_n_q;
  assign nand_re_n_out = re_n_q;
  assign nand_ce_n_out = ce_n_q;
  assign nand_d_oe_out = oe_q;
  assign nand_d_out = wbyte_q;
  assign nand_done_out = done_q;
  assign nand_rdata_out = rdata_nq;

  // ---------------- checking helpers ----------------
  logic [8:0] rd_age_q, wr_age_q;
  logic [4:0] lat_age_q;
  logic rd_seen_q, wr_seen_q;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_age_q <= 9'h000;
      wr_age_q <= 9'h000;
      rd_seen_q <= 1'b0;
      wr_seen_q <= 1'b0;
      lat_age_q <= 5'h00;
    end else begin
      rd_seen_q <= rd_grant | (rd_seen_q & ~wr_grant);
      wr_seen_q <= wr_grant | (wr_seen_q & ~rd_grant);
      rd_age_q <= rd_grant ? 9'h000 : (rd_age_q == 9'h1ff ? rd_age_q : rd_age_q + 9'h001);
      wr_age_q <= wr_grant ? 9'h000 : (wr_age_q == 9'h1ff ? wr_age_q : wr_age_q + 9'h001);
      lat_age_q <= (cle_q | ale_q) ? 5'h00 : (lat_age_q == 5'h1f ? lat_age_q : lat_age_q + 5'h01);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_rd_gap: assert property (rd_grant && rd_seen_q |-> rd_age_q > {1'b0, r2r_f}) // see RULE_01
    else $error("read followed read too soon");
  a_wr_gap: assert property (wr_grant && wr_seen_q |-> wr_age_q > {1'b0, w2w_f}) // see RULE_02
    else $error("write followed write too soon");
  a_ale_re_gap: assert property ($fell(re_n_q) && kind_q |-> lat_age_q == {1'b0, dly_q} + 5'h01) // see RULE_03
    else $error("address latch to read strobe delay wrong");
  a_cle_re_gap: assert property ($fell(re_n_q) && !kind_q |-> lat_age_q == {1'b0, dly_q} + 5'h01) // see RULE_04
    else $error("command latch to read strobe delay wrong");
  a_narrow_lane: assert property (oe_q[1] |-> $past(wide)) // see RULE_05
    else $error("upper lane driven on narrow bus");
  a_bank_off: assert property (!bank_en && st_q == emtn_pkg::NAND_IDLE |=> ce_n_q) // see RULE_06
    else $error("nand access started while bank disabled");
  a_wait_hold: assert property (!re_n_q && wait_en && mem_busy |=> !re_n_q) // see RULE_07
    else $error("strobe released while memory busy");
  a_wait_ignore: assert property (!re_n_q && !wait_en |=> re_n_q) // see RULE_07
    else $error("busy not ignored with wait disabled");
  a_resv_read: assert property (ack_q && avs_read_in |-> rdata_q[31:20] == 12'h000) // see RULE_08
    else $error("reserved bits read nonzero");
  a_bus_answer: assert property ((avs_read_in || avs_write_in) && !ack_q |=> !avs_waitrequest_out)
    else $error("slave answer late");

  c_rd_rd: cover property (rd_grant ##[1:300] rd_grant);
  c_wr_wr: cover property (wr_grant ##[1:300] wr_grant);
  c_nand_addr: cover property (ale_q ##[1:40] done_q);
  c_wait_stretch: cover property (!re_n_q && wait_en && mem_busy ##1 !re_n_q);
endmodule : emtn_ctrl

// >>> verif/emtn_nand_model.sv
`timescale 1ns/10ps
module emtn_nand_model #(
  parameter logic [15:0] WORD = 16'ha5c3
) (
  // clock
  input wire logic clk_sys_in,
  // pins from the controller
  input wire logic nand_ce_n_in,
  input wire logic nand_we_n_in,
  input wire logic [1:0] nand_d_oe_in,
  // busy length after each latch, from the bench
  input wire logic [7:0] busy_len_in,
  // pins to the controller
  output logic [15:0] nand_d_out,
  output logic nand_rb_n_out
);
  logic [15:0] last_q = 16'h0000;
  logic [7:0] busy_q = 8'h00;
  logic we_n_q = 1'b1;
  logic drive;
  assign drive = !nand_ce_n_in && nand_d_oe_in == 2'h0;
  // a released bus toggles every cycle so a stale word never passes as read data
  assign nand_d_out = drive ? WORD : ~last_q;
  assign nand_rb_n_out = busy_q == 8'h00;
  always @(posedge clk_sys_in) begin
    last_q <= nand_d_out;
    we_n_q <= nand_we_n_in;
    if (nand_we_n_in && !we_n_q) begin
      busy_q <= busy_len_in;
    end else if (busy_q != 8'h00) begin
      busy_q <= busy_q - 8'h01;
    end
  end
endmodule : emtn_nand_model

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic sram_req = 1'b0;
  logic sram_we = 1'b0;
  logic nreq = 1'b0;
  logic nph = 1'b0;
  logic [15:0] nbyte = 16'h0;
  logic [7:0] busy_len = 8'h00;
  logic [31:0] rdat;
  logic wait_q, grant, ready, done, ce_n, cle, ale, we_n, re_n, rb_n;
  logic [15:0] nrdata, d_out, d_in;
  logic [1:0] d_oe;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] rv [3] = '{8'h00, 8'hff, 8'h08};
  logic [7:0] wv [3] = '{8'hff, 8'h00, 8'h08};
  logic [3:0] fv [4] = '{4'hf, 4'h0, 4'hf, 4'h0};

  always #5 clk_sys_in = ~clk_sys_in;

  emtn_ctrl i_emtn_ctrl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
    .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_q), .sram_req_in(sram_req), .sram_we_in(sram_we),
    .sram_grant_out(grant), .nand_req_in(nreq), .nand_addr_phase_in(nph),
    .nand_byte_in(nbyte), .nand_ready_out(ready), .nand_done_out(done),
    .nand_rdata_out(nrdata), .nand_ce_n_out(ce_n), .nand_cle_out(cle), .nand_ale_out(ale),
    .nand_we_n_out(we_n), .nand_re_n_out(re_n), .nand_d_out(d_out), .nand_d_oe_out(d_oe),
    .nand_d_in(d_in), .nand_rb_n_in(rb_n));

  emtn_nand_model i_emtn_nand_model (.clk_sys_in(clk_sys_in), .nand_ce_n_in(ce_n),
    .nand_we_n_in(we_n), .nand_d_oe_in(d_oe), .busy_len_in(busy_len),
    .nand_d_out(d_in), .nand_rb_n_out(rb_n));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_sys_in);
    adr <= a;
    wdat <= d;
    be <= b;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk_sys_in);
    while (wait_q !== 1'b0) begin
      @(posedge clk_sys_in);
    end
    q = rdat;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : bus

  // gap in cycles between two grants of one held request
  task automatic sram_gap(input logic w, output int gap);
    int t0;
    t0 = -1;
    gap = -1;
    @(posedge clk_sys_in);
    sram_we <= w;
    sram_req <= 1'b1;
    for (int n = 0; n < 600; n++) begin
      @(posedge clk_sys_in);
      #1;
      if (grant === 1'b1 && t0 >= 0) begin
        gap = n - t0;
        break;
      end
      if (grant === 1'b1) t0 = n;
    end
    @(posedge clk_sys_in);
    sram_req <= 1'b0;
  endtask : sram_gap

  task automatic nand_op(input logic p, output int gap, output int low,
                         output logic [15:0] rd, output logic [7:0] ld, output logic [1:0] loe);
    int t_lat;
    int t_re;
    logic pl;
    t_lat = -1;
    t_re = -1;
    pl = 1'b0;
    low = 0;
    @(posedge clk_sys_in);
    nph <= p;
    nbyte <= 16'h3c96;
    nreq <= 1'b1;
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    nreq <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      #1;
      if (cle === 1'b1 || ale === 1'b1) begin
        check({ale, cle, we_n, ce_n}, {p, !p, 1'b0, 1'b0});
        pl = 1'b1;
        ld = d_out[7:0];
        loe = d_oe;
      end else if (pl) begin
        pl = 1'b0;
        t_lat = n;
      end
      if (re_n === 1'b0) begin
        if (t_re < 0) t_re = n;
        low++;
      end
      if (done === 1'b1) break;
      @(posedge clk_sys_in);
    end
    rd = nrdata;
    gap = t_re - t_lat;
  endtask : nand_op

  function automatic logic [31:0] ctrl(input logic [3:0] ta, input logic [3:0] tc,
                                       input logic [1:0] w, input logic wt);
    ctrl = 32'h0000000c;
    ctrl[emtn_pkg::TAR_LSB +: 4] = ta;
    ctrl[emtn_pkg::TCR_LSB +: 4] = tc;
    ctrl[emtn_pkg::WIDTH_LSB +: 2] = w;
    ctrl[emtn_pkg::WAIT_BIT] = wt;
  endfunction : ctrl

  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] rd;
    logic [7:0] ld;
    logic [1:0] loe;
    logic bad;
    logic p;
    logic w;
    int g;
    int low;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, emtn_pkg::EXT_TIMING_ADDR, 32'h0, 4'hf, q);
    check(q, 32'h00000808);
    bus(1'b0, emtn_pkg::NAND_CTRL_ADDR, 32'h0, 4'hf, q);
    check(q, 32'h00000018);
    bad = 1'b0;
    nreq <= 1'b1;
    repeat (20) begin
      @(posedge clk_sys_in);
      #1;
      if (ready !== 1'b0 || ce_n !== 1'b1 || we_n !== 1'b1) bad = 1'b1;
    end
    check(bad, 1'b0);
    @(posedge clk_sys_in);
    nreq <= 1'b0;
    // reserved width code keeps the old width
    bus(1'b1, emtn_pkg::NAND_CTRL_ADDR, 32'hffffffff, 4'h1, q);
    bus(1'b0, emtn_pkg::NAND_CTRL_ADDR, 32'h0, 4'hf, q);
    check(q, 32'h0000005e);
    bus(1'b1, emtn_pkg::NAND_CTRL_ADDR, 32'hffffffff, 4'hf, q);
    bus(1'b0, emtn_pkg::NAND_CTRL_ADDR, 32'h0, 4'hf, q);
    check(q, 32'h000ffe5e);
    bus(1'b1, emtn_pkg::EXT_TIMING_ADDR, 32'hffffffff, 4'hf, q);
    bus(1'b0, emtn_pkg::EXT_TIMING_ADDR, 32'h0, 4'hf, q);
    check(q, 32'h0000ffff);
    bus(1'b1, 4'h8, 32'hffffffff, 4'hf, q);
    bus(1'b0, 4'h8, 32'h0, 4'hf, q);
    check(q, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, emtn_pkg::EXT_TIMING_ADDR, {16'h0, rv[i], wv[i]}, 4'hf, q);
      sram_gap(1'b0, g);
      check(g, rv[i] + 2);
      sram_gap(1'b1, g);
      check(g, wv[i] + 2);
    end
    // a change of direction is not held off
    @(posedge clk_sys_in);
    sram_we <= 1'b0;
    sram_req <= 1'b1;
    #1;
    while (grant !== 1'b1) begin
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    sram_we <= 1'b1;
    #1;
    check(grant, 1'b1);
    @(posedge clk_sys_in);
    sram_we <= 1'b0;
    #1;
    check(grant, 1'b1);
    @(posedge clk_sys_in);
    sram_req <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      p = i < 2;
      w = i == 0 || i == 3;
      bus(1'b1, emtn_pkg::NAND_CTRL_ADDR, p ? ctrl(fv[i], ~fv[i], {1'b0, w}, 1'b0)
          : ctrl(~fv[i], fv[i], {1'b0, w}, 1'b0), 4'hf, q);
      nand_op(p, g, low, rd, ld, loe);
      check(g, fv[i] + 1);
      check(loe, w ? 2'h3 : 2'h1);
      check(ld, 8'h96);
      if (fv[i] != 4'h0) check(rd, w ? 16'ha5c3 : 16'h00c3);
    end
    busy_len <= 8'h0c;
    bus(1'b1, emtn_pkg::NAND_CTRL_ADDR, ctrl(4'h0, 4'h3, 2'h1, 1'b0), 4'hf, q);
    nand_op(1'b0, g, low, rd, ld, loe);
    check(low, 1);
    bus(1'b1, emtn_pkg::NAND_CTRL_ADDR, ctrl(4'h0, 4'h3, 2'h1, 1'b1), 4'hf, q);
    nand_op(1'b0, g, low, rd, ld, loe);
    check(low > 2, 1'b1);
    wrap_up();
  end
endmodule : testbench
